// ==== src/physical_physical_random_source_health_gate.sv ====
// Health-gated collector turning raw entropy bits into 8 or 16 bit words
`timescale 1ns/1ns
`default_nettype none
module physical_physical_random_source_health_gate
   import physical_random_source_gate_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic raw_bit_i,
   input wire logic raw_valid_i,
   input wire logic wide_word_i,
   input wire logic word_ready_i,
   output logic [15:0] word_o,
   output logic word_valid_o,
   output logic total_fail_o,
   output logic stat_defect_o,
   output logic fault_evt_o,
   output logic healthy_o
);
   gate_regs_t r;
   gate_regs_t next_r;
   logic raw_s1;
   logic raw_s2;
   logic vld_s1;
   logic vld_s2;

   // Raw source is asynchronous analog logic
   always_ff @(posedge clk_i) begin
      raw_s1 <= raw_bit_i;
      raw_s2 <= raw_s1;
      vld_s1 <= raw_valid_i;
      vld_s2 <= vld_s1;
   end

   // Window verdict: the ones count must sit inside the monobit bounds
   function automatic logic count_ok(input logic [CNT_W-1:0] count);
      return (count >= CNT_W'(ONES_MIN)) && (count <= CNT_W'(ONES_MAX));
   endfunction : count_ok

   // Byte words keep the newest eight bits and clear the upper byte
   function automatic logic [15:0] shape_word(input logic wide, input logic [15:0] bits);
      return wide ? bits : {8'h00, bits[7:0]};
   endfunction : shape_word

   always_comb begin
      logic same;
      logic [4:0] need;
      logic [CNT_W-1:0] ones_total;
      same = 1'b0;
      ones_total = '0;
      need = wide_word_i ? WORD_BITS_16 : WORD_BITS_8;
      next_r = r;
      next_r.fault_evt = 1'b0;
      if (r.word_valid && word_ready_i) begin
         next_r.word_valid = 1'b0;
      end
      if (vld_s2 && r.st != ST_FAILED) begin
         // Stuck source shows as a long run of equal bits
         same = r.have_last && (raw_s2 == r.last_bit);
         next_r.rep_cnt = same ? r.rep_cnt + 1'b1 : '0;
         next_r.last_bit = raw_s2;
         next_r.have_last = 1'b1;
         if (same && r.rep_cnt == REP_W'(REP_LIMIT - 2)) begin
            next_r.total_fail = 1'b1;
            next_r.st = ST_FAILED;
            next_r.fault_evt = 1'b1;
         end
         // Judge the window on the count that includes this bit, not the cleared one
         ones_total = r.ones_cnt + CNT_W'(raw_s2);
         next_r.ones_cnt = ones_total;
         next_r.win_cnt = r.win_cnt + 1'b1;
         if (r.win_cnt == CNT_W'(WIN_BITS - 1)) begin
            next_r.win_cnt = '0;
            next_r.ones_cnt = '0;
            if (!count_ok(ones_total)) begin
               next_r.stat_defect = 1'b1;
               next_r.st = ST_FAILED;
               next_r.fault_evt = 1'b1;
            end else if (r.st == ST_STARTUP) begin
               next_r.win_done = r.win_done + 1'b1;
               if (r.win_done == 2'(STARTUP_WINDOWS - 1)) begin
                  next_r.st = ST_RUN;
               end
            end
         end
         // Collect bits; they are only released in ST_RUN, after the start-up windows pass
         next_r.shreg = {r.shreg[14:0], raw_s2};
         next_r.fill = r.fill + 1'b1;
         if (r.fill + 1'b1 >= need) begin
            next_r.fill = '0;
            if (next_r.st == ST_RUN && !next_r.word_valid) begin
               next_r.word = shape_word(wide_word_i, next_r.shreg);
               next_r.word_valid = 1'b1;
            end
         end
      end
      if (next_r.st == ST_FAILED) begin
         next_r.word_valid = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.st <= ST_STARTUP;
      end else begin
         r <= next_r;
      end
   end

   assign word_o = r.word;
   assign word_valid_o = r.word_valid;
   assign total_fail_o = r.total_fail;
   assign stat_defect_o = r.stat_defect;
   assign fault_evt_o = r.fault_evt;
   assign healthy_o = (r.st == ST_RUN);

   // Output gating
   a_no_word_failed: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (total_fail_o || stat_defect_o) |-> !word_valid_o)
      else $error("word offered after fault");

   a_no_word_startup: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (r.st == ST_STARTUP) |-> !word_valid_o)
      else $error("word offered before start-up test");

   a_healthy_clean: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      healthy_o |-> !total_fail_o && !stat_defect_o)
      else $error("healthy while a fault stands");

   a_run_entry: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(healthy_o) |-> $past(r.st == ST_STARTUP))
      else $error("run state entered from wrong state");

   a_startup_windows: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(healthy_o) |-> $past(r.win_cnt) == CNT_W'(WIN_BITS - 1))
      else $error("run state entered off a window boundary");

   // Fault flags are sticky until reset
   a_fail_sticky: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      total_fail_o |=> total_fail_o)
      else $error("total failure flag cleared");

   a_defect_sticky: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      stat_defect_o |=> stat_defect_o && !healthy_o)
      else $error("defect flag cleared");

   a_fail_final: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      total_fail_o |-> !healthy_o)
      else $error("healthy after total failure");

   a_state_final: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (r.st == ST_FAILED) |=> (r.st == ST_FAILED))
      else $error("failed state left without reset");

   // Event pulse
   a_fault_event: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      fault_evt_o |-> (total_fail_o || stat_defect_o) && !$past(r.st == ST_FAILED))
      else $error("fault event without new fault");

   a_evt_single: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      fault_evt_o |=> !fault_evt_o)
      else $error("fault event longer than one cycle");

   a_fail_event: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(total_fail_o) |-> fault_evt_o)
      else $error("total failure without event");

   a_defect_event: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(stat_defect_o) |-> fault_evt_o)
      else $error("defect without event");

   // Word handshake
   a_fail_kills_word: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(total_fail_o) |-> !word_valid_o ##1 !word_valid_o)
      else $error("word survived total failure");

   a_word_hold: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      word_valid_o && !word_ready_i && healthy_o |=> (word_valid_o && $stable(word_o)) || !healthy_o)
      else $error("waiting word changed or vanished");

   a_ready_clears: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      word_valid_o && word_ready_i && !vld_s2 |=> !word_valid_o)
      else $error("accepted word still offered");

   a_byte_mode: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(word_valid_o) && !$past(wide_word_i) |-> word_o[15:8] == 8'h00)
      else $error("byte word has upper bits set");

   a_byte_fill: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      vld_s2 && healthy_o && !wide_word_i && r.fill == 5'h07 && !word_valid_o
      |=> word_valid_o || !healthy_o)
      else $error("full byte not offered");

   a_fill_bound: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      r.fill < WORD_BITS_16)
      else $error("bit fill counter overran");

   // Health counters
   a_stuck_caught: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (r.rep_cnt == REP_W'(REP_LIMIT - 2) && vld_s2 && raw_s2 == r.last_bit
       && r.st != ST_FAILED) |=> total_fail_o)
      else $error("stuck source not flagged");

   a_rep_restart: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      vld_s2 && healthy_o && r.have_last && raw_s2 != r.last_bit |=> r.rep_cnt == '0)
      else $error("run counter not restarted");

   a_win_bound: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      r.win_cnt < CNT_W'(WIN_BITS))
      else $error("window counter overran");

   a_ones_bound: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      r.ones_cnt <= r.win_cnt)
      else $error("ones count above bits seen");

   // Counters only move when a synchronised bit is taken
   a_idle_hold: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !vld_s2 |=> $stable(r.win_cnt) && $stable(r.rep_cnt))
      else $error("counters moved without a bit");
endmodule : physical_physical_random_source_health_gate
`default_nettype wire

// ==== src/physical_random_source_gate_pkg.sv ====
// Constants and types of the random source health gate
package physical_random_source_gate_pkg;
   localparam int unsigned REP_LIMIT = 32;
   localparam int unsigned WIN_BITS = 1024;
   localparam int unsigned ONES_MIN = 432;
   localparam int unsigned ONES_MAX = 592;
   localparam int unsigned STARTUP_WINDOWS = 2;
   localparam int unsigned CNT_W = 11;
   localparam int unsigned REP_W = 6;
   localparam logic [4:0] WORD_BITS_8 = 5'h08;
   localparam logic [4:0] WORD_BITS_16 = 5'h10;

   typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_FAILED} gate_state_t;

   typedef struct packed {
      gate_state_t st;
      logic [1:0] win_done;
      logic [CNT_W-1:0] win_cnt;
      logic [CNT_W-1:0] ones_cnt;
      logic [REP_W-1:0] rep_cnt;
      logic last_bit;
      logic have_last;
      logic [15:0] shreg;
      logic [4:0] fill;
      logic [15:0] word;
      logic word_valid;
      logic total_fail;
      logic stat_defect;
      logic fault_evt;
   } gate_regs_t;
endpackage : physical_random_source_gate_pkg

// ==== verification/word_consumer.sv ====
// Consumer model that takes words from the gate
`timescale 1ns/1ns
`default_nettype none
module word_consumer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic stall_i,
   input wire logic word_valid_i,
   input wire logic [15:0] word_i,
   output logic ready_o,
   output logic [15:0] got_o
);
   assign ready_o = !stall_i;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         got_o <= 16'h0000;
      end else if (word_valid_i && ready_o) begin
         got_o <= word_i;
      end
   end
endmodule : word_consumer
`default_nettype wire

// ==== verification/test_physical_physical_random_source_health_gate.sv ====
// Self-checking bench for the health gate
`timescale 1ns/1ns
`default_nettype none
module test_physical_physical_random_source_health_gate;
   logic clk = 0, rst = 1, rb = 0, rv = 0, wide = 0, stall = 0, rdy, wv, tf, sd, evt, ok;
   logic [15:0] word, got;
   int failures = 0, num_checks = 0, cyc = 0, evts = 0, i;
   logic [32:0] rows [3] = '{{1'b0, 16'h00a5, 16'h00a5}, {1'b1, 16'h5a3c, 16'h5a3c},
      {1'b0, 16'hff69, 16'h0069}};
   physical_physical_random_source_health_gate physical_physical_random_source_health_gate_inst (.clk_i(clk), .sys_rst_i(rst),
      .raw_bit_i(rb), .raw_valid_i(rv), .wide_word_i(wide), .word_ready_i(rdy), .word_o(word),
      .word_valid_o(wv), .total_fail_o(tf), .stat_defect_o(sd), .fault_evt_o(evt), .healthy_o(ok));
   word_consumer word_consumer_inst (.clk_i(clk), .sys_rst_i(rst), .stall_i(stall),
      .word_valid_i(wv), .word_i(word), .ready_o(rdy), .got_o(got));
   initial forever #25 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [15:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         rv <= 1'b1;
         rb <= v[k];
         @(posedge clk);
      end
      rv <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : send
   task automatic finish_test();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   // Ceiling covers start-up plus all scenarios with margin
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (evt === 1'b1)
         evts <= evts + 1;
      if (cyc == 6000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      check({11'h0, wv, tf, sd, evt, ok}, 16'h0000);
      check(word, 16'h0000);
      rst <= 1'b0;
      for (i = 0; i < 255; i++)
         send(16'h00aa, 8);
      check({14'h0, wv, ok}, 16'h0000);
      send(16'h00aa, 8);
      check({14'h0, wv, ok}, 16'h0001);
      for (i = 0; i < 3; i++) begin
         wide <= rows[i][32];
         send(rows[i][31:16], rows[i][32] ? 16 : 8);
         check(got, rows[i][15:0]);
      end
      // Second word formed while the first waits must be dropped
      stall <= 1'b1;
      send(16'h0033, 8);
      send(16'h00cc, 8);
      check({15'h0, wv}, 16'h0001);
      check(word, 16'h0033);
      stall <= 1'b0;
      repeat (2) @(posedge clk);
      check(got, 16'h0033);
      // Hold words back so the failure must kill the one that waits
      stall <= 1'b1;
      send(16'h0000, 16);
      send(16'h0000, 16);
      check({13'h0, tf, ok, wv}, 16'h0004);
      stall <= 1'b0;
      send(16'ha5a5, 16);
      check({15'h0, wv}, 16'h0000);
      check(got, 16'h0033);
      check(evts[15:0], 16'h0001);
      finish_test();
   end
endmodule : test_physical_physical_random_source_health_gate
`default_nettype wire
